// [hdl/bqc_pkg.sv]
`default_nettype none
package bqc_pkg;
    // Register offsets
    localparam logic [7:0] QUEUE_MODE_AND_RATES_ADDR      = 8'h0a;
    localparam logic [7:0] BATCH_COUNT_CTRL_HIGH_ADDR     = 8'h0b;
    localparam logic [7:0] BATCH_COUNT_THRESHOLD_LOW_ADDR = 8'h0c;
    localparam logic [7:0] IRQ_PIN_A_ROUTING_ADDR         = 8'h0d;
    localparam logic [7:0] REG_RESET_VALUE                = 8'h00;

    // Field positions in queue_mode_and_rates
    localparam int TS_DEC_MSB   = 7;
    localparam int TS_DEC_LSB   = 6;
    localparam int TEMP_MSB     = 5;
    localparam int TEMP_LSB     = 4;
    localparam int MODE_MSB     = 2;
    localparam int MODE_LSB     = 0;

    // Field positions in batch_count_ctrl_high
    localparam int PULSED_BIT   = 7;
    localparam int CLEAR_BIT    = 6;
    localparam int SOURCE_BIT   = 5;
    localparam int TH_HIGH_MSB  = 2;

    // Field positions in irq_pin_a_routing
    localparam int RT_STAMP     = 7;
    localparam int RT_CNT       = 6;
    localparam int RT_FULL      = 5;
    localparam int RT_OVR       = 4;
    localparam int RT_TH        = 3;
    localparam int RT_BOOT      = 2;
    localparam int RT_GY        = 1;
    localparam int RT_XL        = 0;

    // Queue mode codes
    localparam logic [2:0] MODE_BYPASS      = 3'h0;
    localparam logic [2:0] MODE_STOP_FULL   = 3'h1;
    localparam logic [2:0] MODE_CONT_TO_STOP = 3'h3;
    localparam logic [2:0] MODE_BYP_TO_CONT = 3'h4;
    localparam logic [2:0] MODE_CONTINUOUS  = 3'h6;
    localparam logic [2:0] MODE_BYP_TO_STOP = 3'h7;

    // Decimation and rate codes
    localparam logic [1:0] TS_OFF     = 2'h0;
    localparam logic [1:0] TS_DEC_1   = 2'h1;
    localparam logic [1:0] TS_DEC_8   = 2'h2;
    localparam logic [4:0] DEC_8_LAST  = 5'h07;
    localparam logic [4:0] DEC_32_LAST = 5'h1f;
    localparam logic [3:0] BDR_OFF     = 4'h0;
    localparam logic [3:0] BDR_SLOWEST = 4'hb;
    localparam logic [1:0] TEMP_OFF    = 2'h0;
    localparam logic [1:0] TEMP_LO     = 2'h1;
    localparam logic [1:0] TEMP_MID    = 2'h2;

    // Timing: clock in hertz, rates in milli-hertz, pulse in nanoseconds
    localparam longint CLK_HZ          = 200_000_000;
    localparam longint TEMP_LO_MHZ     = 1_600;
    localparam longint TEMP_MID_MHZ    = 12_500;
    localparam longint TEMP_HI_MHZ     = 52_000;
    localparam longint TEMP_LO_CYC     = CLK_HZ * 1000 / TEMP_LO_MHZ;
    localparam longint TEMP_MID_CYC    = CLK_HZ * 1000 / TEMP_MID_MHZ;
    localparam longint TEMP_HI_CYC     = CLK_HZ * 1000 / TEMP_HI_MHZ;
    localparam longint DRDY_PULSE_NS   = 75_000;
    localparam longint CLK_PERIOD_NS   = 5;
    localparam longint DRDY_PULSE_CYC  = DRDY_PULSE_NS / CLK_PERIOD_NS;
endpackage : bqc_pkg
`default_nettype wire

// [hdl/bqc_batch_queue_control.sv]
// Overview of operation
// - Timestamps batch at faster sensor rate divided by 1, 8 or 32; 00 off.
// - Temperature batch rate code: 00 off, then 1.6, 12.5, 52 Hz.
// - Mode 000 bypasses the queue; codes 010 and 101 must not be used.
// - Mode 001 stops storing once the queue is full.
// - Mode 110 stores continuously, new sample replaces oldest when full.
// - Mode 011 is continuous while trigger high, then stop-when-full.
// - Mode 100 is bypass while trigger high, then continuous.
// - Mode 111 is bypass while trigger high, then stop-when-full.
// - Pulse-select 0 latches data-ready until the host reads the data.
// - Pulse-select 1 makes each data-ready a 75 us pulse.
// - Writing 1 to clear bit zeroes the counter; bit self-clears.
// - Counter counts accelerometer events at source 0, gyroscope at 1.
// - 11-bit threshold; reaching it clears counter and sets the hit flag.
// - Pin routing acts only while no dynamic address is assigned.
// - Pin shows OR of enabled sources here and companion routing.
// - With dynamic address, full/overrun/threshold/ready raise in-band irq.
// - Enables route hit, full, overrun, threshold, boot, ready flags.
// - A dedicated enable routes the external-stamp flag to the pin.
// - Batch rate code 0000 means the sensor is not batched.
`default_nettype none
module bqc_batch_queue_control
    import bqc_pkg::*;
#(
    parameter longint TEMP_LO_DIV  = TEMP_LO_CYC,
    parameter longint TEMP_MID_DIV = TEMP_MID_CYC,
    parameter longint TEMP_HI_DIV  = TEMP_HI_CYC,
    parameter longint DRDY_PULSE   = DRDY_PULSE_CYC
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       reg_wr_en_in,
    input  wire logic       reg_rd_en_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output var  logic [7:0] reg_rdata_out,
    input  wire logic [3:0] accel_batch_rate_in,
    input  wire logic [3:0] gyro_batch_rate_in,
    input  wire logic       accel_batch_evt_in,
    input  wire logic       gyro_batch_evt_in,
    input  wire logic       trigger_in,
    input  wire logic       queue_full_in,
    input  wire logic       queue_overrun_in,
    input  wire logic       queue_threshold_in,
    input  wire logic       boot_status_in,
    input  wire logic       accel_ready_evt_in,
    input  wire logic       gyro_ready_evt_in,
    input  wire logic       data_read_in,
    input  wire logic       status_read_in,
    input  wire logic       external_stamp_input_in,
    input  wire logic       companion_routing_reg_in,
    input  wire logic       dyn_addr_assigned_in,
    output var  logic       queue_store_en_out,
    output var  logic       queue_overwrite_out,
    output var  logic       ts_batch_out,
    output var  logic       temp_batch_out,
    output var  logic       accel_ready_out,
    output var  logic       gyro_ready_out,
    output var  logic       batch_count_hit_flag_out,
    output var  logic       irq_pin_a_out,
    output var  logic       ibi_req_out
);

    typedef struct packed {
        logic [7:0]  queue_mode_and_rates_reg;
        logic [7:0]  batch_count_ctrl_high_reg;
        logic [7:0]  batch_count_threshold_low_reg;
        logic [7:0]  irq_pin_a_routing_reg;
        logic [7:0]  rdata;
        logic        trig_s1;
        logic        trig_s2;
        logic [10:0] batch_count;
        logic        hit_flag;
        logic [4:0]  ts_dec_cnt;
        logic [26:0] temp_cnt;
        logic [1:0]  drdy;
        logic [13:0] drdy_cnt_xl;
        logic [13:0] drdy_cnt_gy;
        logic        store_en;
        logic        overwrite;
        logic        ts_pulse;
        logic        temp_pulse;
        logic        irq_pin;
        logic        ibi;
    } bqc_state_t;
    bqc_state_t state_reg;
    bqc_state_t state_next;
    // Orders batch rate codes by speed; slowest code ranks just above off
    function automatic logic [3:0] bqc_rate_rank(input logic [3:0] code);
        if (code == BDR_OFF) begin
            bqc_rate_rank = 4'h0;
        end else if (code == BDR_SLOWEST) begin
            bqc_rate_rank = 4'h1;
        end else begin
            bqc_rate_rank = code + 4'h1;
        end
    endfunction : bqc_rate_rank
    logic [2:0]  mode;
    logic [1:0]  ts_sel;
    logic [1:0]  temp_sel;
    logic        pulsed;
    logic [10:0] threshold;
    logic        cnt_evt;
    logic        ts_src_evt;
    logic [26:0] temp_last;
    logic [7:0]  rt;
    // Field extraction from the stored registers
    assign mode      = state_reg.queue_mode_and_rates_reg[MODE_MSB:MODE_LSB];
    assign ts_sel    = state_reg.queue_mode_and_rates_reg[TS_DEC_MSB:TS_DEC_LSB];
    assign temp_sel  = state_reg.queue_mode_and_rates_reg[TEMP_MSB:TEMP_LSB];
    assign pulsed    = state_reg.batch_count_ctrl_high_reg[PULSED_BIT];
    assign threshold = {state_reg.batch_count_ctrl_high_reg[TH_HIGH_MSB:0],
                        state_reg.batch_count_threshold_low_reg};
    assign rt        = state_reg.irq_pin_a_routing_reg;
    // Counter event source select
    assign cnt_evt = state_reg.batch_count_ctrl_high_reg[SOURCE_BIT]
                   ? gyro_batch_evt_in : accel_batch_evt_in;
    // Timestamp follows the faster batched sensor; code 0000 is unbatched
    always_comb begin
        logic [3:0] xl_rank;
        logic [3:0] gy_rank;
        xl_rank = bqc_rate_rank(accel_batch_rate_in);
        gy_rank = bqc_rate_rank(gyro_batch_rate_in);
        if (xl_rank == 4'h0 && gy_rank == 4'h0) begin
            ts_src_evt = 1'b0;
        end else if (xl_rank >= gy_rank) begin
            ts_src_evt = accel_batch_evt_in;
        end else begin
            ts_src_evt = gyro_batch_evt_in;
        end
    end
    // Temperature period select
    always_comb begin
        unique case (temp_sel)
            TEMP_LO:  temp_last = 27'(TEMP_LO_DIV - 1);
            TEMP_MID: temp_last = 27'(TEMP_MID_DIV - 1);
            default:  temp_last = 27'(TEMP_HI_DIV - 1);
        endcase
    end
    // Next-state logic
    always_comb begin
        logic       trig;
        logic       cont;
        logic       stop;
        logic [4:0] ts_last;
        logic       pin_src;
        logic       ibi_src;
        state_next = state_reg;
        trig = state_reg.trig_s2;
        cont = 1'b0;
        stop = 1'b0;
        ts_last = 5'h00;
        pin_src = 1'b0;
        ibi_src = 1'b0;

        // Trigger synchroniser
        state_next.trig_s1 = trigger_in;
        state_next.trig_s2 = state_reg.trig_s1;

        // Self-clearing counter clear bit
        state_next.batch_count_ctrl_high_reg[CLEAR_BIT] = 1'b0;

        // Register writes
        if (reg_wr_en_in) begin
            unique case (reg_addr_in)
                QUEUE_MODE_AND_RATES_ADDR:
                    state_next.queue_mode_and_rates_reg = reg_wdata_in;
                BATCH_COUNT_CTRL_HIGH_ADDR:
                    state_next.batch_count_ctrl_high_reg = reg_wdata_in;
                BATCH_COUNT_THRESHOLD_LOW_ADDR:
                    state_next.batch_count_threshold_low_reg = reg_wdata_in;
                IRQ_PIN_A_ROUTING_ADDR:
                    state_next.irq_pin_a_routing_reg = reg_wdata_in;
                default: ;
            endcase
        end

        // Register reads; clear bit reads as stored, so one only in the cycle after its write
        state_next.rdata = REG_RESET_VALUE;
        if (reg_rd_en_in) begin
            unique case (reg_addr_in)
                QUEUE_MODE_AND_RATES_ADDR:
                    state_next.rdata = state_reg.queue_mode_and_rates_reg;
                BATCH_COUNT_CTRL_HIGH_ADDR:
                    state_next.rdata = state_reg.batch_count_ctrl_high_reg;
                BATCH_COUNT_THRESHOLD_LOW_ADDR:
                    state_next.rdata = state_reg.batch_count_threshold_low_reg;
                IRQ_PIN_A_ROUTING_ADDR:
                    state_next.rdata = rt;
                default: state_next.rdata = REG_RESET_VALUE;
            endcase
        end else begin
            state_next.rdata = state_reg.rdata;
        end

        // Batching-event counter with threshold
        if (state_reg.batch_count_ctrl_high_reg[CLEAR_BIT]) begin
            state_next.batch_count = 11'h000;
        end else if (cnt_evt) begin
            if (state_reg.batch_count + 11'h001 == threshold) begin
                state_next.batch_count = 11'h000;
                state_next.hit_flag = 1'b1;
            end else begin
                state_next.batch_count = state_reg.batch_count + 11'h001;
            end
        end
        // Hit flag clears on status read unless set this cycle
        if (status_read_in && !(cnt_evt && !state_reg
                .batch_count_ctrl_high_reg[CLEAR_BIT]
                && state_reg.batch_count + 11'h001 == threshold)) begin
            state_next.hit_flag = 1'b0;
        end

        // Queue mode decode
        unique case (mode)
            MODE_STOP_FULL:    stop = 1'b1;
            MODE_CONTINUOUS:   cont = 1'b1;
            MODE_CONT_TO_STOP: begin
                cont = trig;
                stop = !trig;
            end
            MODE_BYP_TO_CONT:  cont = !trig;
            MODE_BYP_TO_STOP:  stop = !trig;
            default: ;
        endcase
        state_next.store_en  = cont || (stop && !queue_full_in);
        state_next.overwrite = cont;

        // Timestamp decimation
        state_next.ts_pulse = 1'b0;
        ts_last = (ts_sel == TS_DEC_8) ? DEC_8_LAST : DEC_32_LAST;
        if (ts_sel == TS_OFF) begin
            state_next.ts_dec_cnt = 5'h00;
        end else if (ts_src_evt) begin
            if (ts_sel == TS_DEC_1 || state_reg.ts_dec_cnt == ts_last) begin
                state_next.ts_pulse = 1'b1;
                state_next.ts_dec_cnt = 5'h00;
            end else begin
                state_next.ts_dec_cnt = state_reg.ts_dec_cnt + 5'h01;
            end
        end

        // Temperature batching tick
        state_next.temp_pulse = 1'b0;
        if (temp_sel == TEMP_OFF) begin
            state_next.temp_cnt = 27'h000_0000;
        end else if (state_reg.temp_cnt >= temp_last) begin
            state_next.temp_cnt = 27'h000_0000;
            state_next.temp_pulse = 1'b1;
        end else begin
            state_next.temp_cnt = state_reg.temp_cnt + 27'h000_0001;
        end

        // Data-ready: latched until read, or fixed-length pulse
        if (pulsed) begin
            state_next.drdy[0] = accel_ready_evt_in
                || state_reg.drdy_cnt_xl != 14'h0000;
            state_next.drdy[1] = gyro_ready_evt_in
                || state_reg.drdy_cnt_gy != 14'h0000;
            state_next.drdy_cnt_xl = accel_ready_evt_in
                ? 14'(DRDY_PULSE - 1)
                : (state_reg.drdy_cnt_xl != 14'h0000
                   ? state_reg.drdy_cnt_xl - 14'h0001 : 14'h0000);
            state_next.drdy_cnt_gy = gyro_ready_evt_in
                ? 14'(DRDY_PULSE - 1)
                : (state_reg.drdy_cnt_gy != 14'h0000
                   ? state_reg.drdy_cnt_gy - 14'h0001 : 14'h0000);
        end else begin
            state_next.drdy_cnt_xl = 14'h0000;
            state_next.drdy_cnt_gy = 14'h0000;
            state_next.drdy[0] = accel_ready_evt_in
                || (state_reg.drdy[0] && !data_read_in);
            state_next.drdy[1] = gyro_ready_evt_in
                || (state_reg.drdy[1] && !data_read_in);
        end

        // Interrupt routing
        pin_src = (rt[RT_STAMP] && external_stamp_input_in)
                || (rt[RT_CNT] && state_reg.hit_flag)
                || (rt[RT_BOOT] && boot_status_in)
                || companion_routing_reg_in;
        ibi_src = (rt[RT_FULL] && queue_full_in)
                || (rt[RT_OVR] && queue_overrun_in)
                || (rt[RT_TH] && queue_threshold_in)
                || (rt[RT_GY] && state_reg.drdy[1])
                || (rt[RT_XL] && state_reg.drdy[0]);
        state_next.irq_pin = !dyn_addr_assigned_in
                           && (pin_src || ibi_src);
        state_next.ibi = dyn_addr_assigned_in && ibi_src;
    end
    // State register
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata_out            = state_reg.rdata;
    assign queue_store_en_out       = state_reg.store_en;
    assign queue_overwrite_out      = state_reg.overwrite;
    assign ts_batch_out             = state_reg.ts_pulse;
    assign temp_batch_out           = state_reg.temp_pulse;
    assign accel_ready_out          = state_reg.drdy[0];
    assign gyro_ready_out           = state_reg.drdy[1];
    assign batch_count_hit_flag_out = state_reg.hit_flag;
    assign irq_pin_a_out            = state_reg.irq_pin;
    assign ibi_req_out              = state_reg.ibi;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence wr_mode(logic [2:0] m);
        reg_wr_en_in && reg_addr_in == QUEUE_MODE_AND_RATES_ADDR
            && reg_wdata_in[2:0] == m;
    endsequence

    AST_BYPASS_NO_STORE: assert property (
        mode == MODE_BYPASS |=> !queue_store_en_out && !queue_overwrite_out)
        else $error("bypass mode stores samples");
    AST_STOP_WHEN_FULL: assert property (
        mode == MODE_STOP_FULL && queue_full_in |=> !queue_store_en_out)
        else $error("stop mode stores while full");
    AST_CONTINUOUS: assert property (
        wr_mode(MODE_CONTINUOUS) ##1 !reg_wr_en_in
            |=> queue_store_en_out && queue_overwrite_out)
        else $error("continuous mode not overwriting");
    AST_CONT_TO_STOP: assert property (
        mode == MODE_CONT_TO_STOP && state_reg.trig_s2
            |=> queue_overwrite_out)
        else $error("triggered continuous not overwriting");
    AST_BYP_TO_CONT: assert property (
        mode == MODE_BYP_TO_CONT && state_reg.trig_s2
            |=> !queue_store_en_out)
        else $error("bypass-to-continuous stores under trigger");
    AST_BYP_TO_STOP: assert property (
        mode == MODE_BYP_TO_STOP && !state_reg.trig_s2 && !queue_full_in
            |=> queue_store_en_out && !queue_overwrite_out)
        else $error("bypass-to-stop not storing after trigger");
    AST_LATCHED_READY: assert property (
        !pulsed && accel_ready_out && !data_read_in && !$past(pulsed)
            |=> accel_ready_out)
        else $error("latched ready dropped without read");
    AST_PULSE_HIGH: assert property (
        pulsed && $rose(accel_ready_out) && !accel_ready_evt_in
            |-> state_reg.drdy_cnt_xl == 14'(DRDY_PULSE - 1))
        else $error("ready pulse length wrong");
    AST_CLEAR_SELF: assert property (
        state_reg.batch_count_ctrl_high_reg[CLEAR_BIT] && !reg_wr_en_in
            |=> !state_reg.batch_count_ctrl_high_reg[CLEAR_BIT]
                && state_reg.batch_count == 11'h000)
        else $error("counter clear did not act or stick");
    AST_HIT: assert property (
        cnt_evt && !state_reg.batch_count_ctrl_high_reg[CLEAR_BIT]
            && state_reg.batch_count + 11'h001 == threshold
            |=> batch_count_hit_flag_out && state_reg.batch_count == 11'h000)
        else $error("threshold hit missed");
    AST_IBI_NO_PIN: assert property (
        dyn_addr_assigned_in |=> !irq_pin_a_out)
        else $error("pin driven with dynamic address");
    AST_COMPANION_OR: assert property (
        !dyn_addr_assigned_in && companion_routing_reg_in |=> irq_pin_a_out)
        else $error("companion source not on pin");
endmodule : bqc_batch_queue_control
`default_nettype wire

// [testbench/bqc_sensor_model.sv]
`default_nettype none
module bqc_sensor_model
    import bqc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       accel_on_in,
    input  wire logic       gyro_on_in,
    output var  logic [3:0] accel_rate_out,
    output var  logic [3:0] gyro_rate_out,
    output var  logic       accel_evt_out,
    output var  logic       gyro_evt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] tick_reg;
    // Switched-off sensor reports the not-batched rate code
    assign accel_rate_out = accel_on_in ? 4'h2 : BDR_OFF;
    assign gyro_rate_out  = gyro_on_in ? 4'h1 : BDR_OFF;
    // Accel fires every 4 cycles, gyro every 8, one cycle wide each
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_reg      <= 3'h0;
            accel_evt_out <= 1'h0;
            gyro_evt_out  <= 1'h0;
        end else begin
            tick_reg      <= tick_reg + 3'h1;
            accel_evt_out <= accel_on_in && (tick_reg[1:0] == 2'h3);
            gyro_evt_out  <= gyro_on_in && (tick_reg == 3'h7);
        end
    end
endmodule : bqc_sensor_model
`default_nettype wire

// [testbench/batch_queue_control_irq_route_tb.sv]
`default_nettype none
module batch_queue_control_irq_route_tb;
    import bqc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 6;
    localparam int TDIV[4] = '{0, 20, 10, 5};
    localparam int TSX[4] = '{0, 32, 4, 1};
    localparam logic [23:0] MEXP = 24'h08_cbfa;
    localparam logic [2:0] MD[6] = '{MODE_STOP_FULL, MODE_CONTINUOUS,
        MODE_CONT_TO_STOP, MODE_BYP_TO_CONT, MODE_BYP_TO_STOP, MODE_BYPASS};
    localparam logic [7:0] ADR[4] = '{QUEUE_MODE_AND_RATES_ADDR,
        BATCH_COUNT_CTRL_HIGH_ADDR, BATCH_COUNT_THRESHOLD_LOW_ADDR,
        IRQ_PIN_A_ROUTING_ADDR};
    localparam logic [7:0] MSK[4] = '{8'hf7, 8'ha7, 8'hff, 8'hff};
    logic       clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, trig = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, src = 8'h00, rdata, lf;
    logic       a_on = 1'h0, g_on = 1'h0, a_rdy_evt = 1'h0, g_rdy_evt = 1'h0;
    logic       dread = 1'h0, sread = 1'h0, comp = 1'h0, dyn = 1'h0;
    logic       rd_d1 = 1'h0, rd_d2 = 1'h0, a_evt, g_evt, store, ovw, ts;
    logic       temp, a_rdy, g_rdy, hit, pin, ibi;
    logic [3:0] a_rate, g_rate;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, checked = 0, acnt = 0, gcnt = 0, tscnt = 0;
    int         i, j, k, n;

    always #2.5 clk = ~clk;

    bqc_sensor_model u_sensor (.clk_in(clk), .rstn_in(rstn),
        .accel_on_in(a_on), .gyro_on_in(g_on), .accel_rate_out(a_rate),
        .gyro_rate_out(g_rate), .accel_evt_out(a_evt), .gyro_evt_out(g_evt));

    bqc_batch_queue_control #(.TEMP_LO_DIV(20), .TEMP_MID_DIV(10),
        .TEMP_HI_DIV(5), .DRDY_PULSE(PW)) u_dut (
        .ref_clk_in(clk), .rstn_in(rstn), .reg_wr_en_in(wr),
        .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .accel_batch_rate_in(a_rate),
        .gyro_batch_rate_in(g_rate), .accel_batch_evt_in(a_evt),
        .gyro_batch_evt_in(g_evt), .trigger_in(trig),
        .queue_full_in(src[RT_FULL]), .queue_overrun_in(src[RT_OVR]),
        .queue_threshold_in(src[RT_TH]), .boot_status_in(src[RT_BOOT]),
        .accel_ready_evt_in(a_rdy_evt), .gyro_ready_evt_in(g_rdy_evt),
        .data_read_in(dread), .status_read_in(sread),
        .external_stamp_input_in(src[RT_STAMP]),
        .companion_routing_reg_in(comp), .dyn_addr_assigned_in(dyn),
        .queue_store_en_out(store), .queue_overwrite_out(ovw),
        .ts_batch_out(ts), .temp_batch_out(temp), .accel_ready_out(a_rdy),
        .gyro_ready_out(g_rdy), .batch_count_hit_flag_out(hit),
        .irq_pin_a_out(pin), .ibi_req_out(ibi));

    // Event counters sampled between edges
    always @(negedge clk) begin
        if (a_evt === 1'h1) acnt++;
        if (g_evt === 1'h1) gcnt++;
        if (ts === 1'h1) tscnt++;
    end

    // Read data watcher takes the oldest noted value
    always @(posedge clk) begin
        rd_d1 <= rd;
        rd_d2 <= rd_d1;
    end
    always @(negedge clk)
        if (rd_d2) check("rdata", rdata, exp_q.pop_front());

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    task automatic check(input string nm, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask : cyc

    task automatic wreg(input logic [7:0] a, d);
        @(negedge clk);
        {wr, addr, wdata} = {1'h1, a, d};
        @(negedge clk);
        wr = 1'h0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, e);
        @(negedge clk);
        {rd, addr} = {1'h1, a};
        exp_q.push_back(e);
        cyc(1);
        rd = 1'h0;
        cyc(1);
    endtask : rreg

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'h1;
        @(negedge clk);
        s = 1'h0;
    endtask : pulse

    // Bounded wait on an event count; running out ends the run
    task automatic wait_for(ref int c, input int t);
        for (int w = 0; w < t * 10 + 50 && c < t; w++) @(negedge clk);
        if (c < t) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_for

    initial begin
        cyc(5);
        rstn = 1'h1;
        for (i = 0; i < 4; i++) rreg(ADR[i], REG_RESET_VALUE);
        wreg(8'h0e, 8'hff);
        rreg(8'h0e, 8'h00);
        lf = 8'h4b;
        for (i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            wreg(ADR[i], lf & MSK[i]);
            rreg(ADR[i], lf & MSK[i]);
        end
        for (i = 0; i < 4; i++) wreg(ADR[i], 8'h00);
        $display("done registers");
        for (i = 0; i < 12; i++) begin
            trig = !i[0];
            wreg(QUEUE_MODE_AND_RATES_ADDR, {5'h00, MD[i / 2]});
            cyc(6);
            check("store", store, MEXP[2 * i + 1]);
            check("overwrite", ovw, MEXP[2 * i]);
        end
        src[RT_FULL] = 1'h1;
        wreg(QUEUE_MODE_AND_RATES_ADDR, {5'h00, MODE_STOP_FULL});
        cyc(3);
        check("store full", store, 8'h00);
        src = 8'h00;
        $display("done modes");
        wreg(BATCH_COUNT_CTRL_HIGH_ADDR, 8'h41);
        cyc(2);
        rreg(BATCH_COUNT_CTRL_HIGH_ADDR, 8'h01);
        wreg(BATCH_COUNT_THRESHOLD_LOW_ADDR, 8'h02);
        acnt = 0;
        {a_on, g_on} = 2'h3;
        wait_for(acnt, 257);
        check("hit early", hit, 8'h00);
        wait_for(acnt, 258);
        cyc(2);
        check("hit", hit, 8'h01);
        {a_on, g_on} = 2'h0;
        wreg(BATCH_COUNT_CTRL_HIGH_ADDR, 8'h60);
        wreg(BATCH_COUNT_THRESHOLD_LOW_ADDR, 8'h03);
        pulse(sread);
        cyc(2);
        check("hit cleared", hit, 8'h00);
        gcnt = 0;
        {a_on, g_on} = 2'h3;
        wait_for(gcnt, 3);
        cyc(2);
        check("hit gyro", hit, 8'h01);
        {a_on, g_on} = 2'h0;
        pulse(sread);
        $display("done counter");
        pulse(a_rdy_evt);
        cyc(5);
        check("ready held", a_rdy, 8'h01);
        pulse(dread);
        cyc(2);
        check("ready cleared", a_rdy, 8'h00);
        wreg(BATCH_COUNT_CTRL_HIGH_ADDR, 8'h80);
        pulse(g_rdy_evt);
        n = (g_rdy === 1'h1) ? 1 : 0;
        repeat (20) begin
            @(negedge clk);
            if (g_rdy === 1'h1) n++;
        end
        check("pulse width", n[7:0], PW[7:0]);
        pulse(a_rdy_evt);
        cyc(1);
        check("pulse accel", a_rdy, 8'h01);
        cyc(PW);
        check("pulse accel end", a_rdy, 8'h00);
        $display("done ready");
        for (j = 2; j < 8; j++) begin
            if (j == 6) continue;
            wreg(IRQ_PIN_A_ROUTING_ADDR, 8'h01 << j);
            for (k = 0; k < 2; k++) begin
                dyn = k[0];
                src = 8'h01 << j;
                cyc(3);
                check("pin", pin, {7'h00, !k[0]});
                check("ibi", ibi, {7'h00, k[0] && j > 2 && j < 6});
                src = 8'h00;
                cyc(3);
                check("pin idle", pin | ibi, 8'h00);
            end
        end
        {dyn, comp} = 2'h1;
        wreg(IRQ_PIN_A_ROUTING_ADDR, 8'h00);
        cyc(3);
        check("companion", pin, 8'h01);
        comp = 1'h0;
        $display("done routing");
        for (k = 0; k < 4; k++) begin
            wreg(QUEUE_MODE_AND_RATES_ADDR, {k[1:0], 6'h00});
            cyc(10);
            {acnt, tscnt} = '0;
            a_on = 1'h1;
            wait_for(acnt, 32);
            a_on = 1'h0;
            cyc(4);
            check("stamps", tscnt[7:0], TSX[k][7:0]);
        end
        $display("done timestamps");
        for (k = 1; k < 4; k++) begin
            wreg(QUEUE_MODE_AND_RATES_ADDR, {2'h0, k[1:0], 4'h0});
            for (i = 0; i < 200 && temp !== 1'h1; i++) @(negedge clk);
            @(negedge clk);
            n = 1;
            for (i = 0; i < 200 && temp !== 1'h1; i++) begin
                @(negedge clk);
                n++;
            end
            check("temp gap", n[7:0], TDIV[k][7:0]);
        end
        $display("done temperature");
        print_verdict();
    end
endmodule : batch_queue_control_irq_route_tb
`default_nettype wire
